/* inc/timer_irq_map.svh */
`ifndef TIMER_IRQ_MAP_SVH
`define TIMER_IRQ_MAP_SVH

// Register offsets on the plain register port
`define OFS_EN1      3'h0
`define OFS_FLG1     3'h1
`define OFS_EN2      3'h2
`define OFS_FLG2     3'h3
`define OFS_CTL      3'h4
`define OFS_CNT_HI   3'h5
`define OFS_CNT_LO   3'h6

// Reset values
`define RST_BYTE     8'h00
`define RST_CNT      16'h0000
`define CNT_ALL_ONES 16'hffff

// First flag/enable register bit positions
`define B1_CMP1      7
`define B1_CMP2      6
`define B1_CMP3      5
`define B1_CMP4      4
`define B1_SHARED    3
`define B1_CAP1      2
`define B1_CAP2      1
`define B1_CAP3      0

// Second flag/enable register bit positions
`define B2_WRAP      7
`define B2_TICK      6
`define B2_ROLL      5
`define B2_EDGE      4
`define B2_HI        7
`define B2_LO        4
`define B2_PR_HI     1
`define B2_PR_LO     0

// Control register bit positions
`define BC_SHARED    2
`define BC_RATE_HI   1
`define BC_RATE_LO   0

// Prescaler write window in bus cycles
`define PR_WINDOW    7'd64
`define PR_WIN_ONE   7'd1

// Divider tap lengths (low bits that must be all ones)
`define TICK_BASE    5'd13
`define PRE_LEN_1    3'd0
`define PRE_LEN_4    3'd2
`define PRE_LEN_8    3'd3
`define PRE_LEN_16   3'd4

`endif

/* inc/timer_irq_pkg.sv */
package timer_irq_pkg;

    // Prescaler select write window
    typedef enum logic [1:0] {
        PR_OPEN   = 2'b00,
        PR_LOCKED = 2'b01
    } pr_state_t;

    typedef logic [7:0] byte_t;

endpackage

/* rtl/flag_bank.sv */
`timescale 1ns/1ps

// Sticky event flags, write one to clear, set beats clear
module flag_bank #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clear,
    output logic      [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;   // Next flag state

    // Set has priority so no event is lost
    always_comb begin
        next_flags = (flags & ~clear) | set;
    end

    // Register only
    always_ff @(posedge clk) begin
        if (srst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Clear in the event's own cycle must not drop the event
    set_beats_clear_a: assert property (
        @(posedge clk) disable iff (srst)
        |(set & clear) |=> (flags & $past(set)) == $past(set))
        else $error("flag set lost against clear");
endmodule

/* rtl/tap_divider.sv */
`timescale 1ns/1ps

// Free-running binary divider, pulse when low taps are all ones
module tap_divider #(
    parameter int WIDTH = 16,
    parameter int LW    = 5
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic [LW-1:0] len,
    output logic               tick
);
    logic [WIDTH-1:0] cnt;        // Free count, only reset stops it
    logic [WIDTH-1:0] next_cnt;   // Next count
    logic [WIDTH-1:0] mask;       // Taps selected by len
    logic             next_tick;  // Next pulse

    // Period is 2**len, spaced from the previous pulse
    always_comb begin
        next_cnt  = cnt + 1'b1;
        mask      = ~({WIDTH{1'b1}} << len);
        next_tick = ((cnt & mask) == mask);
    end

    // Register only
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

/* rtl/timer_irq_top.sv */
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "timer_irq_map.svh"

// Behaviour
// - Compare flag plus enable requests interrupt
// - Capture flag plus enable requests interrupt
// - Shared enable follows channel select
// - First enables gate same-position flags
// - Writing one clears flag, zero keeps
// - Counter equal compare value sets flag
// - Shared flag set by selected function
// - Capture edge sets capture flag
// - Counter wrap to zero sets flag
// - Wrap enable gates wrap interrupt
// - Unimplemented bits read zero, except control bits 7..3, which read back as written
// - Prescaler writable once, first 64 cycles, normal mode only
// - Prescaler divides by 1, 4, 8, 16
// - Tick period E over 2^13..2^16
// - Tick divider independent of prescaler
// - Tick divider runs free, reset only
// - Interval timed from previous timeout
// - Timeout sets tick flag, maybe interrupt
// - First tick after one full interval
// - Write bit 6 clears tick flag
// - High enable nibble gates second flags
// - Select zero compare-5, one capture-4
// - Accumulator rollover sets flag, bit 5
// - Accumulator edge sets flag, bit 4
module timer_irq_top (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        normal_mode,
    input  wire logic [15:0] compare_value_1,
    input  wire logic [15:0] compare_value_2,
    input  wire logic [15:0] compare_value_3,
    input  wire logic [15:0] compare_value_4,
    input  wire logic [15:0] compare_value_5,
    input  wire logic [2:0]  capture_edge,
    input  wire logic        capture_channel_four,
    input  wire logic        accum_rollover,
    input  wire logic        accum_edge,
    output logic      [15:0] free_running_counter,
    output logic             irq
);
    // Software-visible state
    timer_irq_pkg::byte_t      en1;        // Capture/compare enables
    timer_irq_pkg::byte_t      en2;        // Wrap/tick/accum enables, divider
    timer_irq_pkg::byte_t      ctl;        // Shared channel select and tick rate
    timer_irq_pkg::byte_t      next_en1;   // Next first enables
    timer_irq_pkg::byte_t      next_en2;   // Next second enables
    timer_irq_pkg::byte_t      next_ctl;   // Next control
    logic [7:0]                flags1;     // First flag register
    logic [3:0]                flags2;     // Implemented second flags
    logic [7:0]                set1;       // Flag set events
    logic [3:0]                set2;       // Flag set events
    logic [7:0]                clr1;       // Write-one clears
    logic [3:0]                clr2;       // Write-one clears

    // Prescaler window
    timer_irq_pkg::pr_state_t  pr_state;   // Window state
    timer_irq_pkg::pr_state_t  next_pr_state;
    logic [6:0]                win_cnt;    // Cycles since reset, held once locked
    logic [6:0]                next_win_cnt;
    logic                      pr_ok;      // Divider write allowed now

    // Counting
    logic [15:0]               next_counter;
    logic                      count_en;   // Prescaled count pulse
    logic                      moved;      // Counter changed last cycle
    logic                      next_moved;
    logic [2:0]                pre_len;    // Prescaler tap length
    logic [4:0]                tick_len;   // Tick tap length
    logic                      tick;       // Periodic timeout pulse
    logic [4:0]                hit;        // Compare matches, ch 1..5
    logic [15:0]               cmp [5];    // Compare values by index

    // Bus and request
    logic [7:0]                next_rdata;
    logic                      next_irq;
    logic                      wr1;        // First flag write
    logic                      wr2;        // Second flag write
    logic                      shared_sel; // One = capture-4

    assign shared_sel = ctl[`BC_SHARED];
    assign wr1        = wr && (addr == `OFS_FLG1);
    assign wr2        = wr && (addr == `OFS_FLG2);
    assign cmp[0]     = compare_value_1;
    assign cmp[1]     = compare_value_2;
    assign cmp[2]     = compare_value_3;
    assign cmp[3]     = compare_value_4;
    assign cmp[4]     = compare_value_5;

    // Counter prescaler, its own divider from clk
    always_comb begin
        case (en2[`B2_PR_HI:`B2_PR_LO])
            2'h0:    pre_len = `PRE_LEN_1;   // tap
            2'h1:    pre_len = `PRE_LEN_4;
            2'h2:    pre_len = `PRE_LEN_8;
            2'h3:    pre_len = `PRE_LEN_16;
            default: pre_len = `PRE_LEN_1;
        endcase
    end

    tap_divider #(
        .WIDTH (4),
        .LW    (3)
    ) u_prescale (
        .clk  (clk),
        .srst (srst),
        .len  (pre_len),
        .tick (count_en)
    );

    // Tick divider never sees the prescaler, only clk, reset and the ctl rate bits
    assign tick_len = `TICK_BASE + {3'h0, ctl[`BC_RATE_HI:`BC_RATE_LO]};

    tap_divider #(
        .WIDTH (16),
        .LW    (5)
    ) u_tick (
        .clk  (clk),
        .srst (srst),
        .len  (tick_len),
        .tick (tick)
    );

    // Counter next value and change marker
    always_comb begin
        next_counter = free_running_counter;
        if (count_en) begin
            next_counter = free_running_counter + 1'b1;
        end
        next_moved = count_en;
    end

    // Counter registers
    always_ff @(posedge clk) begin
        if (srst) begin
            free_running_counter <= `RST_CNT;
            moved                <= 1'b0;
        end else begin
            free_running_counter <= next_counter;
            moved                <= next_moved;
        end
    end

    // Compare once per new count so a match sets a flag once
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            hit[i] = moved && (free_running_counter == cmp[i]);
        end
    end

    // Flag set sources; shared bit obeys the select
    always_comb begin
        set1                = '0;
        set1[`B1_CMP1]      = hit[0];
        set1[`B1_CMP2]      = hit[1];
        set1[`B1_CMP3]      = hit[2];
        set1[`B1_CMP4]      = hit[3];
        set1[`B1_CAP1]      = capture_edge[0];
        set1[`B1_CAP2]      = capture_edge[1];
        set1[`B1_CAP3]      = capture_edge[2];
        if (shared_sel) begin
            set1[`B1_SHARED] = capture_channel_four;
        end else begin
            set1[`B1_SHARED] = hit[4];
        end
        set2                = '0;
        set2[`B2_WRAP-`B2_LO] = count_en && (free_running_counter == `CNT_ALL_ONES);
        set2[`B2_TICK-`B2_LO] = tick;
        set2[`B2_ROLL-`B2_LO] = accum_rollover;
        set2[`B2_EDGE-`B2_LO] = accum_edge;
    end

    // Write-one clears, only on the matching offset
    always_comb begin
        clr1 = wr1 ? wdata : '0;
        clr2 = wr2 ? wdata[`B2_HI:`B2_LO] : '0;
    end

    flag_bank #(
        .WIDTH (8)
    ) u_flags1 (
        .clk   (clk),
        .srst  (srst),
        .set   (set1),
        .clear (clr1),
        .flags (flags1)
    );

    flag_bank #(
        .WIDTH (4)
    ) u_flags2 (
        .clk   (clk),
        .srst  (srst),
        .set   (set2),
        .clear (clr2),
        .flags (flags2)
    );

    // Divider select window; special modes leave it open
    always_comb begin
        next_pr_state = pr_state;
        next_win_cnt  = win_cnt;
        pr_ok         = 1'b0;
        case (pr_state)
            timer_irq_pkg::PR_OPEN: begin
                pr_ok        = 1'b1;
                next_win_cnt = win_cnt + `PR_WIN_ONE;
                // Closes on the first write or after the window
                if ((wr && addr == `OFS_EN2) ||
                    (win_cnt == `PR_WINDOW - `PR_WIN_ONE)) begin
                    next_pr_state = timer_irq_pkg::PR_LOCKED;
                end
            end
            timer_irq_pkg::PR_LOCKED: begin
                pr_ok = 1'b0;
            end
            default: begin
                next_pr_state = timer_irq_pkg::PR_LOCKED;
            end
        endcase
        if (!normal_mode) begin
            pr_ok = 1'b1;
        end
    end

    // Window registers
    always_ff @(posedge clk) begin
        if (srst) begin
            pr_state <= timer_irq_pkg::PR_OPEN;
            win_cnt  <= '0;
        end else begin
            pr_state <= next_pr_state;
            win_cnt  <= next_win_cnt;
        end
    end

    // Software register writes
    always_comb begin
        next_en1 = en1;
        next_en2 = en2;
        next_ctl = ctl;
        if (wr && addr == `OFS_EN1) begin
            next_en1 = wdata;
        end
        if (wr && addr == `OFS_EN2) begin
            next_en2[`B2_HI:`B2_LO] = wdata[`B2_HI:`B2_LO];
            if (pr_ok) begin
                next_en2[`B2_PR_HI:`B2_PR_LO] = wdata[`B2_PR_HI:`B2_PR_LO];
            end
        end
        if (wr && addr == `OFS_CTL) begin
            next_ctl = wdata;
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            en1 <= `RST_BYTE;
            en2 <= `RST_BYTE;
            ctl <= `RST_BYTE;
        end else begin
            en1 <= next_en1;
            en2 <= next_en2;
            ctl <= next_ctl;
        end
    end

    // Read mux; data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = '0;
        if (rd) begin
            case (addr)
                `OFS_EN1:    next_rdata = en1;
                `OFS_FLG1:   next_rdata = flags1;
                `OFS_EN2:    next_rdata = {en2[`B2_HI:`B2_LO], 2'b00,
                                           en2[`B2_PR_HI:`B2_PR_LO]};
                `OFS_FLG2:   next_rdata = {flags2, 4'h0};
                `OFS_CTL:    next_rdata = ctl;
                `OFS_CNT_HI: next_rdata = free_running_counter[15:8];
                `OFS_CNT_LO: next_rdata = free_running_counter[7:0];
                default:     next_rdata = '0;
            endcase
        end
    end

    // Request is the OR of every gated flag
    always_comb begin
        next_irq = |(flags1 & en1) ||
                   |(flags2 & en2[`B2_HI:`B2_LO]);
    end

    // Output registers
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= `RST_BYTE;
            irq   <= 1'b0;
        end else begin
            rdata <= next_rdata;
            irq   <= next_irq;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Locked divider write leaves the select untouched
    sequence locked_write_s;
        pr_state == timer_irq_pkg::PR_LOCKED && normal_mode &&
        wr && addr == `OFS_EN2;
    endsequence

    compare_irq_a: assert property (
        flags1[`B1_CMP1] && en1[`B1_CMP1] |=> irq)
        else $error("compare flag with enable gave no request");

    capture_irq_a: assert property (
        flags1[`B1_CAP1] && en1[`B1_CAP1] |=> irq)
        else $error("capture flag with enable gave no request");

    wrap_mask_a: assert property (
        !(|(flags1 & en1)) && !(|(flags2 & en2[`B2_HI:`B2_LO])) |=> !irq)
        else $error("request without any enabled flag");

    flag_clear_a: assert property (
        wr1 && wdata[`B1_CMP2] && !set1[`B1_CMP2] |=> !flags1[`B1_CMP2])
        else $error("write one did not clear flag");

    set_wins_a: assert property (
        wr2 && wdata[`B2_TICK] && tick |=> flags2[`B2_TICK-`B2_LO])
        else $error("tick lost against clear");

    shared_sel_a: assert property (
        !shared_sel && !hit[4] && !flags1[`B1_SHARED] && capture_channel_four
        |=> !flags1[`B1_SHARED])
        else $error("capture-4 set flag in compare-5 mode");

    counter_wrap_a: assert property (
        count_en && free_running_counter == `CNT_ALL_ONES
        |=> flags2[`B2_WRAP-`B2_LO] && free_running_counter == `RST_CNT)
        else $error("wrap did not set flag");

    divider_lock_a: assert property (
        locked_write_s |=> $stable(en2[`B2_PR_HI:`B2_PR_LO]))
        else $error("divider select changed after lock");

    tick_spacing_a: assert property (
        tick |=> !tick [*8])
        else $error("ticks too close together");

    tick_flag_a: assert property (
        tick |=> flags2[`B2_TICK-`B2_LO])
        else $error("timeout did not set tick flag");

    unimpl_zero_a: assert property (
        rd && addr == `OFS_FLG2 |=> rdata[3:0] == 4'h0)
        else $error("unimplemented flag bits read nonzero");
endmodule

/* testbench/core_model.sv */
`timescale 1ns/1ps

// Processor side of the register port: one-cycle strobes, no wait states
module core_model (
    input  wire logic       clk,
    output logic      [2:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    // Idle bus from time zero
    initial begin
        addr  = 3'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // Single write; software programs the divider early and acks ticks here
    task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d; // Stale data scrambled so nothing leans on it
    endtask

    // Single read; data is picked up by the bench one cycle later
    task automatic bus_read(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a; // Address no longer qualified
    endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps

module testbench;
    logic        clk = 1'b0;          // 10 MHz
    logic        srst = 1'b1;         // Sync reset
    logic        normal_mode = 1'b1;  // Divider write-once when high
    logic [15:0] cv1 = 16'hffff;      // Compare values
    logic [15:0] cv2 = 16'hffff;
    logic [15:0] cv3 = 16'hffff;
    logic [15:0] cv4 = 16'hffff;
    logic [15:0] cv5 = 16'hffff;
    logic [5:0]  ev = 6'h00;          // {edge, rollover, cap4, cap3..1}
    logic [2:0]  addr;                // Bus from core model
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [15:0] frc;                 // Counter output
    logic        irq;
    logic        rd_q = 1'b0;         // Read taken last edge
    logic [15:0] e;                   // {mask, value} note
    logic [15:0] exp_q[$];            // Expected read notes
    logic [7:0]  d;
    integer      seed = 32'h14b2448d;
    int          errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          rel;
    int          t1;
    int          t2;

    always #50 clk = ~clk;

    // Free cycle count for tick timing
    always @(posedge clk) cyc <= cyc + 1;

    timer_irq_top dut (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .normal_mode(normal_mode),
        .compare_value_1(cv1), .compare_value_2(cv2), .compare_value_3(cv3),
        .compare_value_4(cv4), .compare_value_5(cv5),
        .capture_edge(ev[2:0]), .capture_channel_four(ev[3]),
        .accum_rollover(ev[4]), .accum_edge(ev[5]),
        .free_running_counter(frc), .irq(irq)
    );

    core_model core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    task automatic fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        errors++;
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Scoreboard: read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q) begin
            samples_checked++;
            if (exp_q.size() == 0) begin
                fail("read without note");
            end else begin
                e = exp_q.pop_front();
                if ((rdata & e[15:8]) !== e[7:0]) fail("read data");
            end
        end
        rd_q <= rd;
    end

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rd_exp(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
        exp_q.push_back({m, v});
        core.bus_read(a);
    endtask

    task automatic irq_is(input logic v);
        samples_checked++;
        if (irq !== v) fail("request line");
    endtask

    // One-cycle event pulses on the chosen inputs
    task automatic pulse(input logic [5:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
    endtask

    // Counter advance over 16 cycles; window length makes it phase free
    task automatic div_is(input logic [15:0] q);
        logic [15:0] c0;
        c0 = frc;
        repeat (16) @(posedge clk);
        #1;
        samples_checked++;
        if (frc - c0 !== q) fail("prescale rate");
    endtask

    // Bounded wait for the request line to rise
    task automatic wait_rise(output int t);
        int n;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 20000) begin
                fail("no request");
                tally_and_finish();
            end
        end
        t = cyc;
    endtask

    // Acknowledge the tick and see the request drop
    task automatic ack_tick();
        core.bus_write(3'h3, 8'h40);
        settle(3);
        irq_is(1'b0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        settle(1);
        rel = cyc;
        // Divider: first write inside the window sticks, later one refused
        core.bus_write(3'h2, 8'h41);
        rd_exp(3'h2, 8'hff, 8'h41);
        core.bus_write(3'h2, 8'h4f);
        rd_exp(3'h2, 8'hff, 8'h41);
        settle(2);
        div_is(16'h0004);
        @(posedge clk);
        normal_mode <= 1'b0;
        // Every divider code, ending on divide by one
        for (int p = 3; p >= 0; p--) begin
            core.bus_write(3'h2, 8'h40 | 8'(p));
            settle(2);
            div_is(p == 0 ? 16'd16 : 16'd16 >> (p + 1));
        end
        // Plain registers with random data, unmapped place, reserved bits
        d = 8'($random(seed));
        core.bus_write(3'h0, d);
        rd_exp(3'h0, 8'hff, d);
        core.bus_write(3'h1, d);
        rd_exp(3'h1, 8'hff, 8'h00);
        core.bus_write(3'h4, d & 8'hf8);
        rd_exp(3'h4, 8'hff, d & 8'hf8);
        core.bus_write(3'h7, 8'hff);
        rd_exp(3'h7, 8'hff, 8'h00);
        rd_exp(3'h3, 8'h0f, 8'h00);
        core.bus_write(3'h0, 8'h00);
        core.bus_write(3'h4, 8'h00);
        // Tick: first after a full interval, then evenly spaced
        wait_rise(t1);
        samples_checked++;
        if (t1 - rel < 8192 || t1 - rel > 8196) fail("first tick");
        ack_tick();
        core.bus_write(3'h2, 8'h43);
        wait_rise(t2);
        samples_checked++;
        if (t2 - t1 != 8192) fail("tick period");
        core.bus_write(3'h2, 8'h40);
        ack_tick();
        core.bus_write(3'h4, 8'h01);
        wait_rise(t1);
        ack_tick();
        wait_rise(t2);
        samples_checked++;
        if (t2 - t1 != 16384) fail("slow tick period");
        core.bus_write(3'h2, 8'h00);
        core.bus_write(3'h4, 8'h00);
        core.bus_write(3'h3, 8'hf0);
        // Compare matches on all five channels, shared one as compare
        @(posedge clk);
        cv1 <= frc + 16'd41;
        cv2 <= frc + 16'd42;
        cv3 <= frc + 16'd43;
        cv4 <= frc + 16'd44;
        cv5 <= frc + 16'd45;
        core.bus_write(3'h0, 8'hf8);
        settle(60);
        rd_exp(3'h1, 8'hff, 8'hf8);
        irq_is(1'b1);
        core.bus_write(3'h1, 8'h00);
        rd_exp(3'h1, 8'hff, 8'hf8);
        core.bus_write(3'h1, 8'hff);
        settle(2);
        rd_exp(3'h1, 8'hff, 8'h00);
        irq_is(1'b0);
        // Shared channel as capture: compare ignored, capture counted
        core.bus_write(3'h4, 8'h04);
        @(posedge clk);
        cv5 <= frc + 16'd20;
        settle(40);
        rd_exp(3'h1, 8'hff, 8'h00);
        pulse(6'h08);
        settle(2);
        rd_exp(3'h1, 8'hff, 8'h08);
        irq_is(1'b1);
        core.bus_write(3'h1, 8'h08);
        core.bus_write(3'h4, 8'h00);
        pulse(6'h08);
        settle(2);
        rd_exp(3'h1, 8'hff, 8'h00);
        // Captures, only the first one enabled
        core.bus_write(3'h0, 8'h04);
        for (int i = 0; i < 3; i++) begin
            pulse(6'(1 << i));
            settle(2);
            irq_is(i == 0);
            rd_exp(3'h1, 8'hff, 8'(4 >> i));
            core.bus_write(3'h1, 8'(4 >> i));
            settle(2);
            irq_is(1'b0);
        end
        // Capture and its clear in one cycle: the set wins
        fork
            pulse(6'h01);
            core.bus_write(3'h1, 8'h04);
        join
        settle(2);
        rd_exp(3'h1, 8'hff, 8'h04);
        irq_is(1'b1);
        core.bus_write(3'h1, 8'h04);
        settle(2);
        irq_is(1'b0);
        // Accumulator rollover and edge flags; tick bit masked out
        core.bus_write(3'h2, 8'h30);
        pulse(6'h10);
        settle(2);
        irq_is(1'b1);
        rd_exp(3'h3, 8'hbf, 8'h20);
        core.bus_write(3'h3, 8'h20);
        pulse(6'h20);
        settle(2);
        rd_exp(3'h3, 8'hbf, 8'h10);
        core.bus_write(3'h3, 8'h30);
        settle(2);
        irq_is(1'b0);
        // Counter wrap
        core.bus_write(3'h2, 8'h80);
        t1 = 0;
        while (frc !== 16'hffff && t1 < 70000) begin
            settle(1);
            t1++;
        end
        if (t1 >= 70000) begin
            fail("no wrap");
            tally_and_finish();
        end
        settle(3);
        rd_exp(3'h3, 8'hbf, 8'h80);
        irq_is(1'b1);
        core.bus_write(3'h2, 8'h00);
        settle(2);
        irq_is(1'b0);
        settle(3);
        tally_and_finish();
    end
endmodule
